// *** design/flr_read_cfg.sv ***
// Read-parameter store and serial read sequencer with dummy clocks and burst wrap
`timescale 1ns/100ps
`default_nettype none

module flr_read_cfg
    import flr_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic i_rp_wr,
    input wire logic [7:0] i_rp_opcode,
    input wire logic [7:0] i_rp_wdata,
    input wire logic i_qpi_mode,
    output logic [7:0] o_rp_nonvol,
    output logic [7:0] o_rp_vol,
    output logic o_cfg_busy,
    input wire logic i_sck,
    input wire logic i_cs_b,
    input wire logic [3:0] i_io_in,
    output logic [3:0] o_io_out,
    output logic [3:0] o_io_oe,
    output logic [ADDR_BITS-1:0] o_mem_addr,
    input wire logic [7:0] i_mem_rdata,
    output logic o_cmd_rejected
);

    // ------------------------------------------------------------------------
    // System domain: read parameters and the outgoing half of the handshake
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] rp_nv;
        logic [7:0] rp_vol;
        flr_cfg_t shadow;
        logic req_tgl;
        logic ack_s1;
        logic ack_s2;
        logic busy;
    } flr_sys_t;

    // Link side: settings seen by the sequencer, reset only by the system reset
    typedef struct packed {
        logic req_s1;
        logic req_s2;
        logic req_seen;
        flr_cfg_t cfg;
    } flr_lnk_t;

    // Link side: one frame, cleared whenever chip select is high
    typedef struct packed {
        flr_state_t st;
        logic [4:0] cnt;
        logic [7:0] cmd_sr;
        logic [ADDR_BITS-1:0] addr_sr;
        flr_cmd_attr_t attr;
        logic [7:0] byte_sr;
        logic [ADDR_BITS-1:0] mem_addr;
        logic [3:0] io_out;
        logic [3:0] io_oe;
        logic rejected;
    } flr_frm_t;

    flr_sys_t sys_ff;
    flr_sys_t nxt_sys;
    flr_lnk_t lnk_ff;
    flr_lnk_t nxt_lnk;
    flr_frm_t frm_ff;
    flr_frm_t nxt_frm;
    flr_cfg_t want_cfg;
    logic frm_rst_b;
    logic [ADDR_BITS-1:0] wrap_next;

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    function automatic logic [3:0] lane_mask(input logic [1:0] lg);
        case (lg)
            2'd0: lane_mask = 4'h2;
            2'd1: lane_mask = 4'h3;
            default: lane_mask = 4'hF;
        endcase
    endfunction

    function automatic logic [3:0] lane_bits(input logic [7:0] b, input logic [1:0] lg);
        case (lg)
            2'd0: lane_bits = {2'b00, b[7], 1'b0};
            2'd1: lane_bits = {2'b00, b[7:6]};
            default: lane_bits = b[7:4];
        endcase
    endfunction

    // Single lane samples io0; dual io1:io0; quad all four
    function automatic logic [ADDR_BITS-1:0] shift_in(input logic [ADDR_BITS-1:0] sr,
                                                      input logic [3:0] io,
                                                      input logic [1:0] lg);
        case (lg)
            2'd0: shift_in = {sr[ADDR_BITS-2:0], io[0]};
            2'd1: shift_in = {sr[ADDR_BITS-3:0], io[1:0]};
            default: shift_in = {sr[ADDR_BITS-5:0], io};
        endcase
    endfunction

    // ------------------------------------------------------------------------
    // System domain
    // ------------------------------------------------------------------------
    always_comb begin
        nxt_sys = sys_ff;
        nxt_sys.ack_s1 = lnk_ff.req_seen;
        nxt_sys.ack_s2 = sys_ff.ack_s1;
        if (i_rp_wr && i_rp_opcode == OP_SET_RP_NONVOLATILE) begin
            nxt_sys.rp_nv = i_rp_wdata;
        end
        if (i_rp_wr && (i_rp_opcode == OP_SET_RP_VOLATILE ||
                        i_rp_opcode == OP_SET_RP_VOLATILE_ALT)) begin
            nxt_sys.rp_vol = i_rp_wdata;
        end
        want_cfg.qpi = i_qpi_mode;
        want_cfg.wrap_enable_bit = sys_ff.rp_vol[RP_WRAP_EN_BIT];
        want_cfg.burst_len_hi_bit = sys_ff.rp_vol[RP_BURST_HI_BIT];
        want_cfg.burst_len_lo_bit = sys_ff.rp_vol[RP_BURST_LO_BIT];
        // dummy field in bits 6 to 3
        want_cfg.dummy = sys_ff.rp_vol[RP_DUMMY_LSB +: RP_DUMMY_W];
        // Shadow only moves once the link has taken the previous word
        if (sys_ff.req_tgl == sys_ff.ack_s2 && want_cfg != sys_ff.shadow) begin
            nxt_sys.shadow = want_cfg;
            nxt_sys.req_tgl = ~sys_ff.req_tgl;
        end
        nxt_sys.busy = (nxt_sys.req_tgl != nxt_sys.ack_s2);
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sys_ff <= '{rp_nv: RP_RESET, rp_vol: RP_RESET, default: '0};
        end else begin
            sys_ff <= nxt_sys;
        end
    end

    // ------------------------------------------------------------------------
    // Link domain: settings capture
    // ------------------------------------------------------------------------
    always_comb begin
        nxt_lnk = lnk_ff;
        nxt_lnk.req_s1 = sys_ff.req_tgl;
        nxt_lnk.req_s2 = lnk_ff.req_s1;
        if (lnk_ff.req_s2 != lnk_ff.req_seen) begin
            nxt_lnk.cfg = sys_ff.shadow;
            nxt_lnk.req_seen = lnk_ff.req_s2;
        end
    end

    always_ff @(posedge i_sck or negedge i_rst_b) begin
        if (!i_rst_b) begin
            lnk_ff <= '0;
        end else begin
            lnk_ff <= nxt_lnk;
        end
    end

    // ------------------------------------------------------------------------
    // Link domain: frame sequencer
    // ------------------------------------------------------------------------
    // The serial clock stops between frames, so chip select ends the frame
    assign frm_rst_b = i_rst_b & ~i_cs_b;

    flr_wrap_addr #(
        .ADDR_W(ADDR_BITS)
    ) u_wrap (
        .i_addr(frm_ff.mem_addr),
        .i_wrap_enable_bit(lnk_ff.cfg.wrap_enable_bit),
        .i_burst_len_hi_bit(lnk_ff.cfg.burst_len_hi_bit),
        .i_burst_len_lo_bit(lnk_ff.cfg.burst_len_lo_bit),
        .o_next_addr(wrap_next)
    );

    always_comb begin
        logic [7:0] cmd_next;
        logic [ADDR_BITS-1:0] addr_next;
        logic [2:0] a_lg;
        logic [2:0] d_lg;
        cmd_next = lnk_ff.cfg.qpi ? {frm_ff.cmd_sr[3:0], i_io_in} :
                                    {frm_ff.cmd_sr[6:0], i_io_in[0]};
        addr_next = shift_in(frm_ff.addr_sr, i_io_in, frm_ff.attr.addr_lg);
        a_lg = {1'b0, frm_ff.attr.addr_lg} + {2'b00, frm_ff.attr.dtr};
        d_lg = {1'b0, frm_ff.attr.data_lg} + {2'b00, frm_ff.attr.dtr};
        nxt_frm = frm_ff;
        nxt_frm.cnt = 5'(frm_ff.cnt + 1'b1);
        case (frm_ff.st)
            FR_CMD: begin
                nxt_frm.cmd_sr = cmd_next;
                if (frm_ff.cnt == (lnk_ff.cfg.qpi ? 5'h01 : 5'h07)) begin
                    nxt_frm.attr = flr_decode(cmd_next, lnk_ff.cfg);
                    nxt_frm.cnt = '0;
                    nxt_frm.st = nxt_frm.attr.valid ? FR_ADDR : FR_IGNORE;
                    nxt_frm.rejected = !nxt_frm.attr.valid;
                end
            end
            FR_ADDR: begin
                nxt_frm.addr_sr = addr_next;
                if (frm_ff.cnt == 5'((ADDR_BITS >> a_lg) - 1)) begin
                    nxt_frm.mem_addr = addr_next;
                    nxt_frm.cnt = '0;
                    nxt_frm.st = frm_ff.attr.has_mode ? FR_MODE : FR_DUMMY;
                end
            end
            FR_MODE: begin
                // mode bits are only listened to, never driven
                if (frm_ff.cnt == 5'((MODE_BITS >> a_lg) - 1)) begin
                    nxt_frm.cnt = '0;
                    nxt_frm.st = FR_DUMMY;
                end
            end
            FR_DUMMY: begin
                // last dummy edge loads the first byte
                if (frm_ff.cnt == 5'(frm_ff.attr.dummy - 1'b1)) begin
                    nxt_frm.cnt = '0;
                    nxt_frm.st = FR_DATA;
                    nxt_frm.byte_sr = i_mem_rdata;
                    nxt_frm.mem_addr = wrap_next;
                    nxt_frm.io_out = lane_bits(i_mem_rdata, frm_ff.attr.data_lg);
                    nxt_frm.io_oe = lane_mask(frm_ff.attr.data_lg);
                end
            end
            FR_DATA: begin
                if (frm_ff.cnt == 5'((8 >> d_lg) - 1)) begin
                    // next byte address follows the wrap setting
                    nxt_frm.cnt = '0;
                    nxt_frm.byte_sr = i_mem_rdata;
                    nxt_frm.mem_addr = wrap_next;
                end else begin
                    nxt_frm.byte_sr = 8'(frm_ff.byte_sr << (4'd1 << d_lg));
                end
                nxt_frm.io_out = lane_bits(nxt_frm.byte_sr, frm_ff.attr.data_lg);
            end
            FR_IGNORE: begin
                nxt_frm.cnt = frm_ff.cnt;
            end
            default: begin
                nxt_frm.st = FR_IGNORE;
            end
        endcase
    end

    always_ff @(posedge i_sck or negedge frm_rst_b) begin
        if (!frm_rst_b) begin
            frm_ff <= '{st: FR_CMD, default: '0};
        end else begin
            frm_ff <= nxt_frm;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    always_comb begin
        o_rp_nonvol = sys_ff.rp_nv;
        o_rp_vol = sys_ff.rp_vol;
        o_cfg_busy = sys_ff.busy;
        o_io_out = frm_ff.io_out;
        o_io_oe = frm_ff.io_oe;
        o_mem_addr = frm_ff.mem_addr;
        o_cmd_rejected = frm_ff.rejected;
    end

endmodule
`default_nettype wire

// *** design/flr_pkg.sv ***
// Constants, types and command decoding for the flash read-configuration block
// ----------------------------------------------------------------------------
// Functional notes
// - With the wrap-enable bit at 0, burst reads run across the whole array and the burst-length bits are ignored.
// - With the wrap-enable bit at 1, burst reads wrap at the boundary picked by the two burst-length bits.
// - A dummy field of 0 picks per-command defaults (SPI fast 8, QPI fast 6, dual out 8, dual I/O 4, quad out 8, quad I/O 6, same in double rate); 1 to 15 give that many clocks.
// - The dual I/O double-rate read is accepted in SPI mode only, never in QPI mode.
// - Unique-ID read and information-row read use the fast-read dummy setting too.
// - Burst-length bits 00, 01, 10, 11 give wraps of 8, 16, 32 and 64 bytes.
// - The dummy field sits in bits 6 to 3 of the read parameters, written by opcode 65h (non-volatile) or C0h/63h (volatile).
// ----------------------------------------------------------------------------
package flr_pkg;

    // ------------------------------------------------------------------------
    // Read parameter layout
    // ------------------------------------------------------------------------
    localparam int RP_BURST_LO_BIT = 0;
    localparam int RP_BURST_HI_BIT = 1;
    localparam int RP_WRAP_EN_BIT = 2;
    localparam int RP_DUMMY_LSB = 3;
    localparam int RP_DUMMY_W = 4;
    localparam logic [7:0] RP_RESET = 8'h00;
    localparam int ADDR_BITS = 24;
    localparam int MODE_BITS = 8;
    localparam int BURST_MIN_LG = 3;

    // ------------------------------------------------------------------------
    // Opcodes
    // ------------------------------------------------------------------------
    localparam logic [7:0] OP_FAST_READ = 8'h0B;
    localparam logic [7:0] OP_FAST_READ_DDR = 8'h0D;
    localparam logic [7:0] OP_DUAL_OUT = 8'h3B;
    localparam logic [7:0] OP_DUAL_IO = 8'hBB;
    localparam logic [7:0] OP_DUAL_IO_DDR = 8'hBD;
    localparam logic [7:0] OP_QUAD_OUT = 8'h6B;
    localparam logic [7:0] OP_QUAD_IO = 8'hEB;
    localparam logic [7:0] OP_QUAD_IO_DDR = 8'hED;
    localparam logic [7:0] OP_UNIQUE_ID_READ = 8'h4B;
    localparam logic [7:0] OP_INFO_ROW_READ = 8'h68;
    localparam logic [7:0] OP_SET_RP_NONVOLATILE = 8'h65;
    localparam logic [7:0] OP_SET_RP_VOLATILE = 8'hC0;
    localparam logic [7:0] OP_SET_RP_VOLATILE_ALT = 8'h63;

    // ------------------------------------------------------------------------
    // Default dummy clocks per command family
    // ------------------------------------------------------------------------
    localparam logic [4:0] DFLT_DUMMY_SPI_FAST = 5'h08;
    localparam logic [4:0] DFLT_DUMMY_QPI_FAST = 5'h06;
    localparam logic [4:0] DFLT_DUMMY_DUAL_OUT = 5'h08;
    localparam logic [4:0] DFLT_DUMMY_DUAL_IO = 5'h04;
    localparam logic [4:0] DFLT_DUMMY_QUAD_OUT = 5'h08;
    localparam logic [4:0] DFLT_DUMMY_QUAD_IO = 5'h06;

    // ------------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------------
    typedef enum logic [2:0] {
        FR_CMD = 3'b000,
        FR_ADDR = 3'b001,
        FR_MODE = 3'b010,
        FR_DUMMY = 3'b011,
        FR_DATA = 3'b100,
        FR_IGNORE = 3'b101
    } flr_state_t;

    // Settings the link needs from the system side
    typedef struct packed {
        logic qpi;
        logic wrap_enable_bit;
        logic burst_len_hi_bit;
        logic burst_len_lo_bit;
        logic [RP_DUMMY_W-1:0] dummy;
    } flr_cfg_t;

    // Lane counts are log2 (0: one lane, 1: two, 2: four)
    typedef struct packed {
        logic valid;
        logic dtr;
        logic has_mode;
        logic [1:0] addr_lg;
        logic [1:0] data_lg;
        logic [4:0] dummy;
    } flr_cmd_attr_t;

    // ------------------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------------------
    function automatic flr_cmd_attr_t flr_decode(input logic [7:0] op, input flr_cfg_t cfg);
        flr_cmd_attr_t a;
        logic [4:0] dflt;
        logic [1:0] qlg;
        a = '0;
        dflt = DFLT_DUMMY_SPI_FAST;
        qlg = cfg.qpi ? 2'd2 : 2'd0;
        case (op)
            OP_FAST_READ, OP_FAST_READ_DDR, OP_UNIQUE_ID_READ, OP_INFO_ROW_READ: begin
                a.valid = 1'b1;
                a.dtr = (op == OP_FAST_READ_DDR);
                a.addr_lg = qlg;
                a.data_lg = qlg;
                dflt = cfg.qpi ? DFLT_DUMMY_QPI_FAST : DFLT_DUMMY_SPI_FAST;
            end
            OP_DUAL_OUT: begin
                a.valid = !cfg.qpi;
                a.data_lg = 2'd1;
                dflt = DFLT_DUMMY_DUAL_OUT;
            end
            OP_DUAL_IO, OP_DUAL_IO_DDR: begin
                a.valid = !cfg.qpi;
                a.dtr = (op == OP_DUAL_IO_DDR);
                a.has_mode = 1'b1;
                a.addr_lg = 2'd1;
                a.data_lg = 2'd1;
                dflt = DFLT_DUMMY_DUAL_IO;
            end
            OP_QUAD_OUT: begin
                a.valid = !cfg.qpi;
                a.data_lg = 2'd2;
                dflt = DFLT_DUMMY_QUAD_OUT;
            end
            OP_QUAD_IO, OP_QUAD_IO_DDR: begin
                a.valid = 1'b1;
                a.dtr = (op == OP_QUAD_IO_DDR);
                a.has_mode = 1'b1;
                a.addr_lg = 2'd2;
                a.data_lg = 2'd2;
                dflt = DFLT_DUMMY_QUAD_IO;
            end
            default: begin
                a.valid = 1'b0;
            end
        endcase
        a.dummy = (cfg.dummy == '0) ? dflt : {1'b0, cfg.dummy};
        return a;
    endfunction

endpackage

// *** design/flr_wrap_addr.sv ***
// Next burst address with whole-array or burst-length wrap
`timescale 1ns/100ps
`default_nettype none

module flr_wrap_addr
    import flr_pkg::*;
#(
    parameter int ADDR_W = ADDR_BITS
) (
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic i_wrap_enable_bit,
    input wire logic i_burst_len_hi_bit,
    input wire logic i_burst_len_lo_bit,
    output logic [ADDR_W-1:0] o_next_addr
);

    logic [ADDR_W-1:0] mask;
    logic [ADDR_W-1:0] inc;
    logic [ADDR_W-1:0] ones;

    always_comb begin
        ones = '1;
        inc = ADDR_W'(i_addr + 1'b1);
        // 8, 16, 32 or 64 bytes
        mask = ~(ones << (BURST_MIN_LG + {i_burst_len_hi_bit, i_burst_len_lo_bit}));
        if (i_wrap_enable_bit) begin
            o_next_addr = (i_addr & ~mask) | (inc & mask);
        end else begin
            o_next_addr = inc;
        end
    end

endmodule
`default_nettype wire

// *** tb/flr_read_cfg_checker.sv ***
// Assertion checker for the read-configuration block
`timescale 1ns/100ps
`default_nettype none
module flr_read_cfg_checker
    import flr_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic i_rp_wr,
    input wire logic [7:0] i_rp_opcode,
    input wire logic [7:0] i_rp_wdata,
    input wire logic [7:0] o_rp_nonvol,
    input wire logic [7:0] o_rp_vol,
    input wire logic i_sck,
    input wire logic i_cs_b,
    input wire logic [3:0] o_io_oe,
    input wire logic [ADDR_BITS-1:0] o_mem_addr,
    input wire logic o_cmd_rejected
);
    // Burst step: whole array, or only the low bits inside the burst window
    function automatic logic [23:0] f_step(input logic [23:0] a, input logic [7:0] rp);
        logic [23:0] m;
        m = rp[2] ? (24'h00_0008 << rp[1:0]) - 24'h00_0001 : 24'hFF_FFFF;
        return (a & ~m) | ((a + 24'h00_0001) & m);
    endfunction
    sequence s_nv_wr;
        i_rp_wr && i_rp_opcode == OP_SET_RP_NONVOLATILE;
    endsequence
    sequence s_v_wr;
        i_rp_wr && (i_rp_opcode == OP_SET_RP_VOLATILE || i_rp_opcode == OP_SET_RP_VOLATILE_ALT);
    endsequence
    // Two data samples in a row; the first sample of a frame always sees 0
    sequence s_two_data;
        o_io_oe != 4'h0 ##1 o_io_oe != 4'h0;
    endsequence
    AST_NV_WRITE: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        s_nv_wr |=> o_rp_nonvol == $past(i_rp_wdata)) else $error("nonvolatile copy missed write");
    AST_V_WRITE: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        s_v_wr |=> o_rp_vol == $past(i_rp_wdata)) else $error("volatile copy missed write");
    AST_NV_HOLD: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        !(i_rp_wr && i_rp_opcode == OP_SET_RP_NONVOLATILE) |=> $stable(o_rp_nonvol))
        else $error("nonvolatile copy changed without write");
    AST_V_HOLD: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        !(i_rp_wr && (i_rp_opcode == OP_SET_RP_VOLATILE || i_rp_opcode == OP_SET_RP_VOLATILE_ALT))
        |=> $stable(o_rp_vol)) else $error("volatile copy changed without write");
    AST_IDLE_QUIET: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        i_cs_b [*2] |-> o_io_oe == 4'h0 && !o_cmd_rejected) else $error("activity while deselected");
    AST_REJ_NO_DRIVE: assert property (@(posedge i_sck) disable iff (!i_rst_b)
        o_cmd_rejected |-> o_io_oe == 4'h0) else $error("refused command drives pins");
    AST_LANES_HOLD: assert property (@(posedge i_sck) disable iff (!i_rst_b)
        s_two_data |-> o_io_oe == $past(o_io_oe)) else $error("lane set changed in data phase");
    AST_ADDR_STEP: assert property (@(posedge i_sck) disable iff (!i_rst_b)
        s_two_data ##0 $changed(o_mem_addr) |-> o_mem_addr == f_step($past(o_mem_addr), o_rp_vol))
        else $error("burst address step wrong");
    AST_OE_SHAPE: assert property (@(posedge i_sck) disable iff (!i_rst_b)
        $rose(o_io_oe != 4'h0) |-> o_io_oe inside {4'h2, 4'h3, 4'hF}) else $error("bad lane set");
endmodule
bind flr_read_cfg flr_read_cfg_checker flr_read_cfg_checker_inst (.i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b), .i_rp_wr(i_rp_wr), .i_rp_opcode(i_rp_opcode), .i_rp_wdata(i_rp_wdata),
    .o_rp_nonvol(o_rp_nonvol), .o_rp_vol(o_rp_vol), .i_sck(i_sck), .i_cs_b(i_cs_b),
    .o_io_oe(o_io_oe), .o_mem_addr(o_mem_addr), .o_cmd_rejected(o_cmd_rejected));
`default_nettype wire

// *** tb/flr_host_model.sv ***
// Host serial flash controller model with released-line behaviour
`timescale 1ns/100ps
`default_nettype none
module flr_host_model (
    output logic o_sck,
    output logic o_cs_b,
    output logic [3:0] o_io,
    input wire logic [3:0] i_dev_out,
    input wire logic [3:0] i_dev_oe,
    input wire logic i_rej
);
    logic [3:0] drv = 4'h0;
    logic [3:0] drv_oe = 4'h0;
    logic [3:0] flt = 4'h5;
    logic [3:0] smp;
    logic [3:0] soe;
    logic [3:0] oe_pre;
    logic [3:0] oe_first;
    logic rej_seen;
    logic [7:0] rx [0:79];
    initial begin
        o_sck = 1'b0;
        o_cs_b = 1'b1;
    end
    // Undriven lines flip every clock so a stale value never passes as data
    always @(posedge o_sck) flt <= ~flt;
    assign o_io = (i_dev_oe & i_dev_out) | (~i_dev_oe & drv_oe & drv) | (~i_dev_oe & ~drv_oe & flt);
    task automatic tick;
        #40 o_sck = 1'b1;
        #40 smp = o_io;
        soe = i_dev_oe;
        o_sck = 1'b0;
    endtask
    task automatic send(input logic [7:0] v, input int ln);
        for (int c = 0; c < 8 / ln; c++) begin
            drv_oe = (ln == 1) ? 4'h1 : 4'((1 << ln) - 1);
            drv = 4'(v >> (8 - ln));
            v = v << ln;
            tick();
        end
    endtask
    task automatic frame(input logic [7:0] op, input logic [23:0] a, input int cl, input int al,
        input int ml, input int nd, input int dl, input int nb);
        logic [7:0] b;
        o_cs_b = 1'b0;
        send(op, cl);
        if (al > 0) begin
            send(a[23:16], al);
            send(a[15:8], al);
            send(a[7:0], al);
        end
        if (ml > 0) send(8'h00, al);
        drv_oe = 4'h0;
        for (int d = 1; d < nd; d++) tick();
        oe_pre = soe;
        for (int i = 0; i < nb; i++) begin
            b = 8'h00;
            for (int c = 0; c < 8 / dl; c++) begin
                tick();
                if (i == 0 && c == 0) oe_first = soe;
                b = (dl == 1) ? {b[6:0], smp[1]} : 8'((b << dl) | (smp & 4'((1 << dl) - 1)));
            end
            rx[i] = b;
        end
        rej_seen = i_rej;
        o_cs_b = 1'b1;
        #80;
    endtask
endmodule
`default_nettype wire

// *** tb/flr_read_cfg_tb.sv ***
// Self-checking bench for the read-configuration block
`timescale 1ns/100ps
`default_nettype none
module flr_read_cfg_tb
    import flr_pkg::*;
;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic rp_wr = 1'b0;
    logic qpi = 1'b0;
    logic [7:0] rp_op = 8'h00;
    logic [7:0] rp_data = 8'h00;
    logic [7:0] nonvol, vol, mrd, d;
    logic sck, cs_b, busy, rej;
    logic [3:0] io_in, io_out, io_oe;
    logic [23:0] maddr;
    int n_fail = 0;
    int num_checks = 0;
    logic [7:0] spi_ops [7] = '{8'h0B, 8'h3B, 8'hBB, 8'h6B, 8'hEB, 8'h4B, 8'h68};
    logic [7:0] qpi_ops [3] = '{8'h0B, 8'hEB, 8'h68};
    logic [7:0] bad_ops [4] = '{8'h3B, 8'hBB, 8'hBD, 8'h6B};
    function automatic logic [7:0] memv(input logic [23:0] a);
        return a[7:0] ^ a[23:16] ^ 8'h3C;
    endfunction
    function automatic logic [23:0] ea(input logic [23:0] a, input int i, input logic [7:0] p);
        logic [23:0] m;
        m = p[2] ? (24'h00_0008 << p[1:0]) - 24'h00_0001 : 24'hFF_FFFF;
        return (a & ~m) | ((a + 24'(i)) & m);
    endfunction
    assign mrd = memv(maddr);
    initial begin
        forever #50 clk = ~clk;
    end
    flr_read_cfg flr_read_cfg_inst (.i_clk_sys(clk), .i_rst_b(rst_b), .i_rp_wr(rp_wr),
        .i_rp_opcode(rp_op), .i_rp_wdata(rp_data), .i_qpi_mode(qpi), .o_rp_nonvol(nonvol),
        .o_rp_vol(vol), .o_cfg_busy(busy), .i_sck(sck), .i_cs_b(cs_b), .i_io_in(io_in),
        .o_io_out(io_out), .o_io_oe(io_oe), .o_mem_addr(maddr), .i_mem_rdata(mrd),
        .o_cmd_rejected(rej));
    flr_host_model flr_host_model_inst (.o_sck(sck), .o_cs_b(cs_b), .o_io(io_in),
        .i_dev_out(io_out), .i_dev_oe(io_oe), .i_rej(rej));
    task automatic chk(input logic ok, input string msg);
        num_checks++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask
    task automatic close_out;
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic wr(input logic [7:0] op, input logic [7:0] v);
        @(posedge clk);
        rp_wr <= 1'b1;
        rp_op <= op;
        rp_data <= v;
        @(posedge clk);
        rp_wr <= 1'b0;
        @(negedge clk);
    endtask
    // New settings, then a refused frame keeps the serial clock running for the crossing
    task automatic cfg(input logic [7:0] v, input logic q);
        @(posedge clk);
        qpi <= q;
        wr(OP_SET_RP_VOLATILE, v);
        chk(vol === v, "volatile write");
        repeat (3) @(posedge clk);
        // Lane count may switch mid-frame here, so this frame only runs the clock
        flr_host_model_inst.frame(8'h00, 24'h00_0000, 1, 1, 0, 0, 1, 0);
        for (int k = 0; k < 50 && busy !== 1'b0; k++) @(posedge clk);
        chk(busy === 1'b0, "settings crossing stuck");
        flr_host_model_inst.frame(8'h00, 24'h00_0000, q ? 4 : 1, 0, 0, 0, 1, 0);
        chk(flr_host_model_inst.rej_seen === 1'b1, "unknown opcode accepted");
    endtask
    task automatic rd(input logic [7:0] op, input logic q, input logic [23:0] a, input int nb);
        int cl, al, ml, dl, nd, df;
        logic [3:0] m;
        cl = q ? 4 : 1;
        al = cl;
        dl = cl;
        ml = 0;
        df = q ? 6 : 8;
        case (op)
            OP_DUAL_OUT: dl = 2;
            OP_QUAD_OUT: dl = 4;
            OP_DUAL_IO: begin
                al = 2; dl = 2; ml = 1; df = 4;
            end
            OP_QUAD_IO: begin
                al = 4; dl = 4; ml = 1; df = 6;
            end
            default: ;
        endcase
        nd = (d[6:3] == 4'h0) ? df : int'(d[6:3]);
        m = (dl == 1) ? 4'h2 : (dl == 2) ? 4'h3 : 4'hF;
        flr_host_model_inst.frame(op, a, cl, al, ml, nd, dl, nb);
        chk(flr_host_model_inst.oe_pre === 4'h0, "drive before last dummy");
        chk(flr_host_model_inst.oe_first === m, "no data after last dummy");
        for (int i = 0; i < nb; i++)
            chk(flr_host_model_inst.rx[i] === memv(ea(a, i, d)), "read byte");
    endtask
    initial begin
        #5_000_000;
        n_fail++;
        close_out();
    end
    initial begin
        void'($urandom(32'h9f02a355));
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        @(negedge clk);
        chk(nonvol === 8'h00 && vol === 8'h00 && busy === 1'b0 && io_oe === 4'h0, "reset");
        d = 8'($urandom);
        wr(OP_SET_RP_NONVOLATILE, d);
        chk(nonvol === d && vol === 8'h00, "nonvolatile write");
        wr(OP_SET_RP_VOLATILE_ALT, ~d);
        chk(vol === ~d && nonvol === d, "alternate volatile write");
        wr(8'h66, 8'h5A);
        chk(vol === ~d && nonvol === d, "foreign opcode wrote");
        for (int z = 0; z < 2; z++) begin
            foreach (spi_ops[i]) begin
                d = {1'($urandom), z ? 4'($urandom_range(15, 1)) : 4'h0, 3'($urandom)};
                cfg(d, 1'b0);
                rd(spi_ops[i], 1'b0, 24'($urandom), 3);
            end
            foreach (qpi_ops[i]) begin
                d = {1'b0, z ? 4'($urandom_range(15, 1)) : 4'h0, 3'($urandom)};
                cfg(d, 1'b1);
                rd(qpi_ops[i], 1'b1, 24'($urandom), 3);
            end
        end
        foreach (bad_ops[i]) begin
            flr_host_model_inst.frame(bad_ops[i], 24'h00_0000, 4, 0, 0, 0, 1, 0);
            chk(flr_host_model_inst.rej_seen === 1'b1, "QPI refusal");
        end
        d = {1'b0, 4'h1, 3'b011};
        cfg(d, 1'b0);
        flr_host_model_inst.frame(OP_DUAL_IO_DDR, 24'h00_0000, 1, 0, 0, 0, 1, 0);
        chk(flr_host_model_inst.rej_seen === 1'b0, "SPI dual double-rate refused");
        // Double-rate fast read: address in 12 clocks, one dummy, data on io1 only
        flr_host_model_inst.frame(OP_FAST_READ_DDR, 24'h00_0000, 1, 2, 0, 1, 2, 1);
        chk(flr_host_model_inst.oe_pre === 4'h0 && flr_host_model_inst.oe_first === 4'h2,
            "double-rate dummy timing");
        rd(OP_FAST_READ, 1'b0, 24'hFF_FFFC, 8);
        for (int bl = 0; bl < 4; bl++) begin
            d = {1'b0, 4'h2, 1'b1, 2'(bl)};
            cfg(d, 1'b0);
            rd(OP_FAST_READ, 1'b0, 24'($urandom), (8 << bl) + 3);
        end
        close_out();
    end
endmodule
`default_nettype wire
